// ---- logic/hbp_host_bus_port.sv ----
// host bus port: address latching, strobes, dword write, byte or word read
`timescale 1ns/1ps
// How it works
// - muxed or indexed addressing by config input
// - 8 or 16 bit bus, no bytes in 16
// - separate strobes or enable plus direction
// - polarity inputs for cs, rd, wr, latches
// - byte order from config or address latch
// - fifo select steers writes and reads
// - single phase 16 pins or dual phase 8
// - single phase captures all on low latch
// - upper pins never driven in 8-bit mode
// - chip select qualifies latches when enabled
// - latched address kept until reset or relatch
// - dual phase low and high, any order
// - dual phase upper pins carry no address
// - 8-bit byte address from pins directly
// - 16-bit word address shifted to bytes
// - byte order pin just above address
// - fifo select pin two above address
// - two words or four bytes per dword
// - write cycle from cs and wr or enable
// - trailing edge places data in assembly
// - writes ignored until first read done
// - low order select little, high big
// - counter steps, full dword writes once
module hbp_host_bus_port
  import hbp_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  // configuration levels
  input  wire logic              cfgMuxMode,   // 1 muxed, 0 indexed
  input  wire logic              cfgBus16,     // 1 16-bit, 0 8-bit
  input  wire logic              cfgEnbDir,    // enable / direction
  input  wire logic              cfgDualPhase, // two latch phases
  input  wire logic              cfgCsQual,    // cs qualifies latch
  input  wire logic              csActHigh,    // polarity of cs
  input  wire logic              rdActHigh,    // rd or direction=read
  input  wire logic              wrActHigh,    // wr or enable
  input  wire logic              aleActHigh,   // both latch strobes
  input  wire logic              cfgIdxBigEnd, // order, indexed mode
  input  wire logic [HBP_AW-1:0] idxAddr,      // indexed address
  // host pins
  input  wire logic              csPin,
  input  wire logic              rdPin,        // rd or direction
  input  wire logic              wrPin,        // wr or enable
  input  wire logic              lowAddrLatchStrobe,
  input  wire logic              highAddrLatchStrobe,
  input  wire logic [15:0]       adIn,
  output logic      [15:0]       adOut,
  output logic      [15:0]       adOe,
  // internal side
  output hbp_wr_t                regWr,        // dword write pulse
  output hbp_rd_t                rdSel,        // read in progress
  input  wire logic [HBP_DW-1:0] rdData,       // data for rdSel
  output hbp_rd_t                rdDone,       // last part read
  output logic                   wrAllowed     // first read seen
);

  // ****************************************************************
  // strobe decoding ahead of the synchroniser
  // ****************************************************************
  logic csAct;        // chip select active
  logic rdLvl;        // rd pin at its active level
  logic wrLvl;        // wr pin at its active level
  logic wrCyc;        // write cycle level
  logic rdCyc;        // read cycle level
  logic low_addr_latch_strobe;        // low latch strobe active
  logic high_addr_latch_strobe;        // high latch strobe active

  // polarity folding, a pin equal to its active level is active
  always_comb begin
    csAct = csPin ~^ csActHigh;
    rdLvl = rdPin ~^ rdActHigh;
    wrLvl = wrPin ~^ wrActHigh;
    low_addr_latch_strobe = lowAddrLatchStrobe ~^ aleActHigh;
    high_addr_latch_strobe = highAddrLatchStrobe ~^ aleActHigh;
    // enable mode: wr pin enables, rd pin tells direction
    if (cfgEnbDir) begin
      wrCyc = wrLvl & ~rdLvl;
      rdCyc = wrLvl & rdLvl;
    end else begin
      wrCyc = csAct & wrLvl;
      rdCyc = csAct & rdLvl;
    end
  end

  // ****************************************************************
  // synchroniser and edge detection
  // ****************************************************************
  localparam int SW = 21;          // pins plus five strobes
  logic [SW-1:0] s2;               // synchronised levels
  logic [SW-1:0] s3_reg;           // one cycle older copy
  logic [15:0]   ad3;              // pins at last active sample
  logic          cs3;              // cs at last active sample
  logic          wrFall;           // write cycle trailing edge
  logic          rdFall;           // read cycle trailing edge
  logic          rdActive;         // read cycle in progress
  logic          loFall;           // low latch trailing edge
  logic          hiFall;           // high latch trailing edge
  logic          loQual;           // low latch accepted
  logic          hiQual;           // high latch accepted

  // strobes and pins share one synchroniser so they stay aligned
  hbp_sync #(
    .W       (SW)
  ) uSync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .asyncIn ({adIn, high_addr_latch_strobe, low_addr_latch_strobe, rdCyc, wrCyc, csAct}),
    .syncOut (s2)
  );

  // older copy for edges
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s3_reg <= '0;
    end else if (clkEn) begin
      s3_reg <= s2;
    end
  end

  // an edge is active in the older copy, idle in the newer one
  always_comb begin
    ad3      = s3_reg[20:5];
    cs3      = s3_reg[0];
    wrFall   = s3_reg[1] & ~s2[1];
    rdFall   = s3_reg[2] & ~s2[2];
    rdActive = s2[2];
    loFall   = s3_reg[3] & ~s2[3];
    hiFall   = s3_reg[4] & ~s2[4];
    // qualification ignores cs entirely when switched off
    loQual   = cfgMuxMode & loFall & (cs3 | ~cfgCsQual);
    hiQual   = cfgMuxMode & hiFall & (cs3 | ~cfgCsQual)
             & cfgDualPhase;
  end

  // ****************************************************************
  // address latch
  // ****************************************************************
  hbp_latch_t latch_reg;           // held address and selects

  // kept across any number of accesses until relatched
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      latch_reg <= '{HBP_ADDR_RST, 1'b0, 1'b0};
    end else if (clkEn) begin
      // low strobe: whole address in single phase
      if (loQual && !cfgDualPhase) begin
        if (cfgBus16) begin
          latch_reg.addr    <= {ad3[8:0], 1'b0};
          latch_reg.bigEnd  <= ad3[HBP_SP16_END];
          latch_reg.fifoSel <= ad3[HBP_SP16_FIFO];
        end else begin
          latch_reg.addr    <= ad3[9:0];
          latch_reg.bigEnd  <= ad3[HBP_SP8_END];
          latch_reg.fifoSel <= ad3[HBP_SP8_FIFO];
        end
      end
      // low strobe: lower part only in dual phase
      if (loQual && cfgDualPhase) begin
        if (cfgBus16) begin
          latch_reg.addr[8:0] <= {ad3[7:0], 1'b0};
        end else begin
          latch_reg.addr[7:0] <= ad3[7:0];
        end
      end
      // high strobe: upper bits and selects, lower pins only
      if (hiQual) begin
        if (cfgBus16) begin
          latch_reg.addr[9] <= ad3[0];
          latch_reg.bigEnd  <= ad3[HBP_DP16_END];
          latch_reg.fifoSel <= ad3[HBP_DP16_FIFO];
        end else begin
          latch_reg.addr[9:8] <= ad3[1:0];
          latch_reg.bigEnd    <= ad3[HBP_DP8_END];
          latch_reg.fifoSel   <= ad3[HBP_DP8_FIFO];
        end
      end
    end
  end

  // ****************************************************************
  // effective access target
  // ****************************************************************
  logic [HBP_AW-1:0] effAddr;      // byte address in use
  logic              effBig;       // byte order in use
  logic              effFifo;      // fifo direct in use
  logic [1:0]        lane;         // lowest internal lane touched

  // indexed mode takes address and order from plain inputs
  always_comb begin
    effAddr = cfgMuxMode ? latch_reg.addr : idxAddr;
    effBig  = cfgMuxMode ? latch_reg.bigEnd : cfgIdxBigEnd;
    effFifo = cfgMuxMode & latch_reg.fifoSel;
    // 16-bit hosts carry no byte address bit
    if (cfgBus16) begin
      effAddr[0] = 1'b0;
    end
    lane = hbp_lane(effAddr[1:0], effBig, cfgBus16);
  end

  // ****************************************************************
  // first read gate
  // ****************************************************************
  // writes stay dead after reset until one read has ended
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wrAllowed <= 1'b0;
    end else if (clkEn && rdFall) begin
      wrAllowed <= 1'b1;
    end
  end

  // ****************************************************************
  // write path
  // ****************************************************************
  logic      partValid;            // accepted write edge
  hbp_part_t part;                 // placed host data

  // data sampled while the strobe was last seen active
  always_comb begin
    partValid = wrFall & wrAllowed;
    part      = hbp_place(ad3, lane, effBig, cfgBus16);
  end

  // dword assembly and single internal write
  hbp_dword_asm uAsm (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clkEn     (clkEn),
    .partValid (partValid),
    .part      (part),
    .partAddr  (effAddr),
    .partFifo  (effFifo),
    .bus16     (cfgBus16),
    .wrOut     (regWr)
  );

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [2:0] rdCnt_reg;           // parts read of this dword
  logic [2:0] rdCnt_next;          // count after this part
  logic [2:0] rdParts;             // parts per dword

  always_comb begin
    rdParts    = cfgBus16 ? HBP_PARTS16 : HBP_PARTS8;
    rdCnt_next = rdCnt_reg + 3'h1;
  end

  // selection held for the internal side while a read runs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdSel <= '0;
    end else if (clkEn) begin
      rdSel.valid   <= rdActive;
      rdSel.addr    <= {effAddr[HBP_AW-1:2], 2'b00};
      rdSel.fifoSel <= effFifo;
    end
  end

  // read counter and last-part pulse
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdCnt_reg <= 3'h0;
      rdDone    <= '0;
    end else if (clkEn) begin
      rdDone.valid <= rdFall && (rdCnt_next >= rdParts);
      if (rdFall) begin
        rdCnt_reg      <= (rdCnt_next >= rdParts) ? 3'h0 : rdCnt_next;
        rdDone.addr    <= {effAddr[HBP_AW-1:2], 2'b00};
        rdDone.fifoSel <= effFifo;
      end
    end
  end

  // pin drive, upper byte never driven on an 8-bit bus
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      adOut <= 16'h0000;
      adOe  <= 16'h0000;
    end else if (clkEn) begin
      if (rdActive && rdSel.valid) begin
        adOut <= hbp_pick(rdData, lane, effBig, cfgBus16);
        adOe  <= cfgBus16 ? HBP_OE16 : HBP_OE8;
      end else begin
        adOut <= 16'h0000;
        adOe  <= 16'h0000;
      end
    end
  end

endmodule

// ---- shared/hbp_pkg.sv ----
// package: constants, carriers and lane helpers of the host bus port
package hbp_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int HBP_AW   = 10;     // internal byte address width
  localparam int HBP_DW   = 32;     // internal register width
  localparam int HBP_PINS = 16;     // shared address / data pins

  // ****************************************************************
  // pin positions of the selects during the latch phase
  // ****************************************************************
  localparam int HBP_SP8_END   = 10;  // single phase, 8-bit bus
  localparam int HBP_SP8_FIFO  = 11;
  localparam int HBP_SP16_END  = 9;   // single phase, 16-bit bus
  localparam int HBP_SP16_FIFO = 10;
  localparam int HBP_DP8_END   = 2;   // dual phase high part, 8-bit
  localparam int HBP_DP8_FIFO  = 3;
  localparam int HBP_DP16_END  = 1;   // dual phase high part, 16-bit
  localparam int HBP_DP16_FIFO = 2;

  // ****************************************************************
  // reset values and counts
  // ****************************************************************
  localparam logic [9:0]  HBP_ADDR_RST = 10'h000; // latched address
  localparam logic [2:0]  HBP_PARTS8   = 3'h4;    // bytes per dword
  localparam logic [2:0]  HBP_PARTS16  = 3'h2;    // words per dword
  localparam logic [15:0] HBP_OE8      = 16'h00ff; // 8-bit drive
  localparam logic [15:0] HBP_OE16     = 16'hffff; // 16-bit drive

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [HBP_AW-1:0] addr;     // byte address
    logic              bigEnd;   // byte order select
    logic              fifoSel;  // fifo direct select
  } hbp_latch_t;

  typedef struct packed {
    logic              valid;    // one-cycle commit pulse
    logic [HBP_AW-1:0] addr;     // dword aligned byte address
    logic              fifoSel;  // goes to the write data fifo
    logic [HBP_DW-1:0] data;     // assembled dword
  } hbp_wr_t;

  typedef struct packed {
    logic              valid;    // access in progress / done
    logic [HBP_AW-1:0] addr;     // dword aligned byte address
    logic              fifoSel;  // comes from the read data fifo
  } hbp_rd_t;

  typedef struct packed {
    logic [3:0]        be;       // byte lanes written
    logic [HBP_DW-1:0] data;     // data replicated on all lanes
  } hbp_part_t;

  // ****************************************************************
  // lane helpers
  // ****************************************************************
  // lowest internal byte lane touched by a host access
  function automatic logic [1:0] hbp_lane(logic [1:0] a, logic big,
                                          logic bus16);
    hbp_lane = bus16 ? {a[1] ^ big, 1'b0} : (a ^ {big, big});
  endfunction

  // place a host byte or word onto internal lanes
  function automatic hbp_part_t hbp_place(logic [15:0] d,
                                          logic [1:0] lane,
                                          logic big, logic bus16);
    logic [15:0] w;
    w = big ? {d[7:0], d[15:8]} : d;
    hbp_place.data = bus16 ? {w, w} : {4{d[7:0]}};
    hbp_place.be   = bus16 ? (lane[1] ? 4'hc : 4'h3)
                           : 4'(4'h1 << lane);
  endfunction

  // pick a host byte or word out of an internal dword
  function automatic logic [15:0] hbp_pick(logic [31:0] q,
                                           logic [1:0] lane,
                                           logic big, logic bus16);
    logic [15:0] w;
    logic [7:0]  b;
    w = q[{lane[1], 4'h0} +: 16];
    b = q[{lane, 3'h0} +: 8];
    hbp_pick = bus16 ? (big ? {w[7:0], w[15:8]} : w) : {8'h00, b};
  endfunction

endpackage

// ---- logic/hbp_sync.sv ----
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module hbp_sync
  import hbp_pkg::*;
#(
  parameter int W = 1              // number of levels
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         clkEn,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  // width check at elaboration
  if (W < 1) begin : gBadW
    $error("hbp_sync: width must be at least one");
  end

  logic [W-1:0] meta_reg;          // first stage, read by second only

  // ****************************************************************
  // two stages
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      syncOut  <= '0;
    end else if (clkEn) begin
      meta_reg <= asyncIn;
      syncOut  <= meta_reg;
    end
  end

endmodule

// ---- logic/hbp_dword_asm.sv ----
// assembles host bytes or words into one internal dword write
`timescale 1ns/1ps
module hbp_dword_asm
  import hbp_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  input  wire logic              partValid,   // one write trailing edge
  input  wire hbp_part_t         part,        // lanes and data
  input  wire logic [HBP_AW-1:0] partAddr,    // byte address
  input  wire logic              partFifo,    // fifo direct select
  input  wire logic              bus16,       // 16-bit host bus
  output hbp_wr_t                wrOut        // commit to registers
);

  logic [HBP_DW-1:0] asm_reg;   // dword being assembled
  logic [2:0]        cnt_reg;   // parts written so far
  logic [2:0]        cnt_next;  // count after this part
  logic [2:0]        parts;     // parts per dword
  logic [HBP_DW-1:0] merged;    // dword with this part merged

  // ****************************************************************
  // merge and count
  // ****************************************************************
  always_comb begin
    parts    = bus16 ? HBP_PARTS16 : HBP_PARTS8;
    cnt_next = cnt_reg + 3'h1;
    for (int i = 0; i < 4; i++) begin
      merged[i*8 +: 8] = part.be[i] ? part.data[i*8 +: 8]
                                    : asm_reg[i*8 +: 8];
    end
  end

  // counter steps on each write edge, wraps after a whole dword
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_reg <= 3'h0;
      asm_reg <= '0;
    end else if (clkEn && partValid) begin
      asm_reg <= merged;
      cnt_reg <= (cnt_next >= parts) ? 3'h0 : cnt_next;
    end
  end

  // single internal write once every part has arrived
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wrOut <= '0;
    end else if (clkEn) begin
      wrOut.valid <= partValid && (cnt_next >= parts);
      if (partValid) begin
        wrOut.addr    <= {partAddr[HBP_AW-1:2], 2'b00};
        wrOut.fifoSel <= partFifo;
        wrOut.data    <= merged;
      end
    end
  end

endmodule

// ---- bench/hbp_host_bus_port_assertions.sv ----
// checker: port-level properties of the host bus port
`timescale 1ns/1ps
module hbp_host_bus_port_chk
  import hbp_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        cfgBus16,
  input wire logic [15:0] adOe,
  input wire hbp_wr_t     regWr,
  input wire hbp_rd_t     rdSel,
  input wire hbp_rd_t     rdDone,
  input wire logic        wrAllowed
);
  // ************************************************
  // properties, all on sys_clk outside reset
  // ************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_upper_quiet: assert property (
    !cfgBus16 |-> adOe[15:8] == 8'h00) else $error("upper pins driven");
  a_oe_width: assert property (
    adOe != 16'h0000 |-> adOe == (cfgBus16 ? HBP_OE16 : HBP_OE8))
    else $error("partial pin drive");
  a_oe_follows_read: assert property (
    adOe != 16'h0000 |-> rdSel.valid || $past(rdSel.valid))
    else $error("drive without read");
  a_gate_closed: assert property (
    !wrAllowed |-> !regWr.valid) else $error("write before read");
  a_gate_sticks: assert property (
    wrAllowed |=> wrAllowed) else $error("write gate closed again");
  a_wr_single: assert property (
    regWr.valid |=> !regWr.valid) else $error("long write pulse");
  a_done_single: assert property (
    rdDone.valid |=> !rdDone.valid) else $error("long read pulse");
  a_wr_aligned: assert property (
    regWr.valid |-> regWr.addr[1:0] == 2'b00) else $error("odd address");
endmodule
bind hbp_host_bus_port hbp_host_bus_port_chk i_hbp_host_bus_port_chk (
  .sys_clk, .rst_n, .cfgBus16, .adOe, .regWr, .rdSel, .rdDone,
  .wrAllowed);

// ---- bench/hbp_host_model.sv ----
// behavioural 8/16-bit host driving the shared pins
`timescale 1ns/1ps
module hbp_host_model (
  input  wire logic        sys_clk,
  input  wire logic        bus16,
  input  wire logic        enbDir,
  input  wire logic        dual,
  input  wire logic        csq,
  input  wire logic        pol,
  input  wire logic [15:0] adBus,
  output logic             csPin,
  output logic             rdPin,
  output logic             wrPin,
  output logic             lowAddrLatchStrobe,
  output logic             highAddrLatchStrobe,
  output logic      [15:0] adDrv
);
  logic        csOn = 0, rdOn = 0, wrOn = 0, loOn = 0, hiOn = 0;
  logic [15:0] hV = 16'h0000, hM = 16'h0000, junk = 16'h0000;
  // cs active low when pol is high, other strobes follow pol
  assign csPin = csOn ^ pol;
  assign rdPin = rdOn ~^ pol;
  assign wrPin = wrOn ~^ pol;
  assign lowAddrLatchStrobe = loOn ~^ pol;
  assign highAddrLatchStrobe = hiOn ~^ pol;
  // released pins show the inverse of their last level
  assign adDrv = (hV & hM) | (junk & ~hM);
  always @(negedge sys_clk) junk <= ~adDrv;
  task automatic waitN(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // one latch strobe, value held around its trailing edge
  task automatic strobe(input logic hi, input logic [15:0] v, m);
    hV = v;
    hM = m;
    waitN(4);
    csOn = csq;
    loOn = !hi;
    hiOn = hi;
    waitN(4);
    loOn = 0;
    hiOn = 0;
    waitN(4);
    csOn = 0;
    hM = 16'h0000;
    waitN(4);
  endtask
  // address phase: selects sit just above the top address bit
  task automatic latch(input logic [9:0] a, input logic big, fifo, hf);
    logic [15:0] v;
    v = bus16 ? {5'h00, fifo, big, a[9:1]} : {4'h0, fifo, big, a};
    if (dual && hf) strobe(1, v >> 8, 16'h00ff);
    strobe(0, v, dual ? 16'h00ff : 16'hffff);
    if (dual && !hf) strobe(1, v >> 8, 16'h00ff);
  endtask
  // one data cycle; r is the bus just before release
  task automatic access(input logic isRd, input logic [15:0] w,
                        output logic [15:0] r);
    hV = w;
    hM = isRd ? 16'h0000 : bus16 ? 16'hffff : 16'h00ff;
    csOn = 1;
    rdOn = isRd;
    waitN(1);
    wrOn = enbDir | !isRd;
    waitN(7);
    r = adBus;
    wrOn = 0;
    rdOn = rdOn & enbDir;
    waitN(3);
    rdOn = 0;
    csOn = 0;
    hM = 16'h0000;
    waitN(4);
  endtask
endmodule

// ---- bench/hbp_host_bus_port_tb_top.sv ----
// testbench: host bus port against a behavioural host
`timescale 1ns/1ps
`define CHK(g, w) begin \
  totalChecks++; \
  if ((g) !== (w)) begin \
    errorCnt++; \
    $display("unexpected at %0t ns: got %0h want %0h", $time, g, w); \
  end \
end
module hbp_host_bus_port_tb_top
  import hbp_pkg::*;
;
  typedef struct packed {
    logic        b16, access_strobe_enable, dp, csq, pol, big, fifo, hf;
    logic [9:0]  base;
    logic [31:0] wrExp;
  } hbp_row_t;
  // ************************************************
  // rows: config bits, dword base, assembled write
  // ************************************************
  hbp_row_t rows [8] = '{
    {8'b00000000, 10'h000, 32'ha3a2a1a0}, {8'b01011100, 10'h3fc, 32'ha0a1a2a3},
    {8'b10001010, 10'h104, 32'hb1c1b0c0}, {8'b11010100, 10'h3fc, 32'hc0b0c1b1},
    {8'b00110010, 10'h2a8, 32'ha3a2a1a0}, {8'b01101101, 10'h15c, 32'ha0a1a2a3},
    {8'b10100111, 10'h3f0, 32'hc0b0c1b1}, {8'b11111000, 10'h0c8, 32'hb1c1b0c0}};
  logic        sys_clk = 0, rst_n = 0, bus16 = 0, enbDir = 0, dual = 0;
  logic        csq = 0, mcsq = 0, pol = 0, mux = 1, idxBig = 0;
  logic        clkEn = 1;
  logic [9:0]  idxAddr = 10'h000;
  logic        csPin, rdPin, wrPin, wrAllowed;
  logic        lowAddrLatchStrobe, highAddrLatchStrobe;
  logic [15:0] adOut, adOe, adDrv, adBus, rd;
  hbp_wr_t     regWr, lastWr;
  hbp_rd_t     rdSel, rdDone, lastRd;
  hbp_row_t    hr;
  int          errorCnt = 0, totalChecks = 0, cyc = 0;
  int          wrCnt = 0, rdCnt = 0, m;
  hbp_host_bus_port i_hbp_host_bus_port (
    .sys_clk, .rst_n, .clkEn, .cfgMuxMode(mux), .cfgBus16(bus16),
    .cfgEnbDir(enbDir), .cfgDualPhase(dual), .cfgCsQual(csq),
    .csActHigh(~pol), .rdActHigh(pol), .wrActHigh(pol), .aleActHigh(pol),
    .cfgIdxBigEnd(idxBig), .idxAddr, .csPin, .rdPin, .wrPin,
    .lowAddrLatchStrobe, .highAddrLatchStrobe, .adIn(adBus), .adOut,
    .adOe, .regWr, .rdSel, .rdDone, .wrAllowed,
    .rdData(rdSel.fifoSel ? 32'hddccbbaa : 32'h44332211));
  hbp_host_model i_hbp_host_model (
    .sys_clk, .bus16, .enbDir, .dual, .csq(mcsq), .pol, .adBus, .csPin,
    .rdPin, .wrPin, .lowAddrLatchStrobe, .highAddrLatchStrobe, .adDrv);
  always #10 sys_clk = ~sys_clk;
  // shared pins: device drive wins where enabled
  assign adBus = (adOut & adOe) | (adDrv & ~adOe);
  // catch commit pulses, cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (rst_n && regWr.valid === 1'b1) begin
      wrCnt++;
      lastWr = regWr;
    end
    if (rst_n && rdDone.valid === 1'b1) begin
      rdCnt++;
      lastRd = rdDone;
    end
    if (cyc == 40000) begin
      errorCnt++;
      completeRun();
    end
  end
  task automatic completeRun();
    $display("checks %0d mismatches %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // apply a row's straps under a 3-cycle reset
  task automatic setup(input hbp_row_t r);
    {bus16, enbDir, dual, csq, pol} = {r.b16, r.access_strobe_enable, r.dp, r.csq, r.pol};
    mcsq = r.csq;
    rst_n = 0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1;
    @(negedge sys_clk);
  endtask
  // all parts of one dword, relatching each part
  task automatic run(input hbp_row_t r, input logic isRd);
    logic [1:0]  ln;
    logic [15:0] w;
    logic [31:0] bd;
    bd = r.fifo ? 32'hddccbbaa : 32'h44332211;
    for (int p = 0; p < (r.b16 ? 2 : 4); p++) begin
      ln = 2'(p) ^ (r.b16 ? {1'b0, r.big} : {r.big, r.big});
      w = r.b16 ? {8'hb0 + 8'(p), 8'hc0 + 8'(p)} : 16'(8'ha0 + 8'(p));
      i_hbp_host_model.latch(r.base + 10'(r.b16 ? 2 * p : p), r.big,
                             r.fifo, r.hf);
      i_hbp_host_model.access(isRd, w, rd);
      w = r.b16 ? bd[16 * ln +: 16] : 16'(bd[8 * ln +: 8]);
      if (r.b16 && r.big) w = {w[7:0], w[15:8]};
      if (isRd) `CHK(r.b16 ? rd : 16'(rd[7:0]), w)
    end
  endtask
  initial begin
    @(negedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      setup(rows[i]);
      m = rdCnt;
      run(rows[i], 1'b1);
      `CHK(rdCnt, m + 1)
      `CHK({lastRd.addr, lastRd.fifoSel}, {rows[i].base, rows[i].fifo})
      m = wrCnt;
      run(rows[i], 1'b0);
      `CHK(wrCnt, m + 1)
      `CHK(lastWr[42:0], {rows[i].base, rows[i].fifo, rows[i].wrExp})
      $display("row %0d done", i);
    end
    // fresh reset: writes ignored, unqualified latch refused
    hr = {8'b00010000, 10'h040, 32'ha3a2a1a0};
    setup(hr);
    `CHK({regWr, rdSel, rdDone, adOe, wrAllowed}, 0)
    m = wrCnt;
    run(hr, 1'b0);
    `CHK(wrCnt, m)
    mcsq = 0;
    i_hbp_host_model.latch(10'h080, 1'b0, 1'b0, 1'b0);
    repeat (4) i_hbp_host_model.access(1'b1, 16'h0000, rd);
    `CHK(lastRd.addr, 10'h040)
    `CHK(wrAllowed, 1'b1)
    mcsq = 1;
    run(hr, 1'b0);
    `CHK(wrCnt, m + 1)
    $display("gate test done");
    // indexed addressing ignores latches
    mux = 0;
    idxAddr = 10'h2c5;
    idxBig = 1;
    i_hbp_host_model.latch(10'h100, 1'b0, 1'b1, 1'b0);
    for (int k = 0; k < 4; k++) begin
      i_hbp_host_model.access(1'b1, 16'h0000, rd);
      `CHK(rd[7:0], 8'h33)
    end
    `CHK({lastRd.addr, lastRd.fifoSel}, {10'h2c4, 1'b0})
    $display("indexed test done");
    // frozen clock enable: a whole dword of reads leaves no trace
    clkEn = 0;
    m = rdCnt;
    repeat (4) i_hbp_host_model.access(1'b1, 16'h0000, rd);
    clkEn = 1;
    repeat (4) @(negedge sys_clk);
    `CHK(rdCnt, m)
    `CHK(adOe, 16'h0000)
    $display("clock enable test done");
    completeRun();
  end
endmodule
